//--- rtl/spfs_params.svh
// Purpose: constants of the stop-mode supply-fault sequencer
// Assumes: mclk at 100 MHz
// Notes: times in their own unit, cycle counts derived from them
`ifndef SPFS_PARAMS_SVH
`define SPFS_PARAMS_SVH

// ****************************************
// clock and timing
// ****************************************
`define SPFS_MCLK_MHZ 100
// least dip length that counts as a fault
`define SPFS_DETECT_NS 2000
`define SPFS_DETECT_CYC ((`SPFS_DETECT_NS * `SPFS_MCLK_MHZ + 999) / 1000)
// crystal warm-up interval, least time
`define SPFS_XTAL_SETTLE_US 2000
`define SPFS_XTAL_SETTLE_CYC (`SPFS_XTAL_SETTLE_US * `SPFS_MCLK_MHZ)
// settle margin after powering the monitor on a wake-up check
`define SPFS_WAKE_CHK_CYC (`SPFS_DETECT_CYC + 4)

// ****************************************
// periodic re-check
// ****************************************
`define SPFS_INTV_LOG2_BASE 10
`define SPFS_SAMPLE_TICKS 2
`define SPFS_CONFIRM_TICKS 1
`define SPFS_RING_CNT_W 14

// ****************************************
// reset values and addresses
// ****************************************
`define SPFS_DISABLE_RST 1'b1
`define SPFS_UTIL_ENTRY 16'h8000
`define SPFS_ADDR_W 16

`endif

//--- rtl/spfs_pkg.sv
// Purpose: types of the stop-mode supply-fault sequencer
// Assumes: nothing beyond the constants header
// Notes: comparator bits are high while the supply is above the threshold
package spfs_pkg;

  // comparator results, one bit per threshold
  typedef struct packed {
    logic above_warning;
    logic above_reset;
    logic above_poweron;
  } spfs_cmp_type;

  // sequencer states
  typedef enum logic [3:0] {
    SPFS_RUN,
    SPFS_STOP,
    SPFS_WAKE_CHECK,
    SPFS_WARMUP,
    SPFS_POR_HOLD,
    SPFS_RST_WAIT,
    SPFS_RST_SAMPLE,
    SPFS_RST_CONFIRM,
    SPFS_RST_WARMUP
  } spfs_state_type;

  // interrupt source taken on stop-mode exit
  typedef enum logic [1:0] {
    SPFS_DISP_NONE,
    SPFS_DISP_PFAIL,
    SPFS_DISP_WAKE
  } spfs_disp_type;

endpackage

//--- rtl/spfs_filter.sv
// Purpose: per-threshold dip filter, a low comparator counts only after a full window
// Assumes: inputs already synchronised to mclk
// Notes: an unarmed bit reads as supply good, the monitor being unpowered
`timescale 1ns/10ps
`include "spfs_params.svh"
module spfs_filter
  import spfs_pkg::*;
#(
  parameter int unsigned CYC = `SPFS_DETECT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire spfs_cmp_type raw_i,
  input wire spfs_cmp_type arm_i,
  output spfs_cmp_type good_o
);

  localparam int unsigned CW = $clog2(CYC + 1);

  logic [2:0] raw;
  logic [2:0] arm;
  wire logic [2:0] good;

  assign raw = raw_i;
  assign arm = arm_i;
  assign good_o = good;

  // ****************************************
  // one window counter per threshold
  // ****************************************
  for (genvar b = 0; b < 3; b++) begin : g_bit
    logic [CW-1:0] cnt_q;
    logic good_q;
    // each bit has its own flop, so no vector is shared between processes
    assign good[b] = good_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt_q <= '0;
        good_q <= 1'b1;
      end else if (ce_i) begin
        if (!arm[b] || raw[b]) begin
          cnt_q <= '0;
          good_q <= 1'b1; // recovery is taken at once
        end else if (cnt_q == CW'(CYC - 1)) begin
          good_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
  end

endmodule

//--- rtl/spfs_seq.sv
// Purpose: stop-mode supply-fault sequencer, drives regulator, crystal, monitor and cpu reset
// Assumes: one clock; ring oscillator and comparators arrive as pins
// Notes: ring oscillator is sampled, its rising edges become ticks
`timescale 1ns/10ps
`include "spfs_params.svh"
module spfs_seq
  import spfs_pkg::*;
#(
  parameter int unsigned XTAL_CYC = `SPFS_XTAL_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic ring_clk_i,
  input wire spfs_cmp_type cmp_i,
  input wire logic stop_req_i,
  input wire logic wake_irq_i,
  input wire logic pfail_prio_high_i,
  input wire logic disable_wr_i,
  input wire logic disable_val_i,
  input wire logic [1:0] interval_sel_i,
  input wire logic flag_clear_i,
  output logic regulator_en_o,
  output logic crystal_en_o,
  output logic monitor_pwr_o,
  output logic cpu_reset_o,
  output logic supply_warning_flag_o,
  output logic stop_exit_o,
  output spfs_disp_type dispatch_o,
  output logic resume_o,
  output logic [`SPFS_ADDR_W-1:0] resume_addr_o,
  output logic stop_monitor_disable_o
);

  localparam int unsigned TW = $clog2(XTAL_CYC + `SPFS_WAKE_CHK_CYC + 1);
  localparam int unsigned RW = `SPFS_RING_CNT_W;

  spfs_state_type state_q;
  spfs_cmp_type cmp_s1_q, cmp_s2_q, cmp_good, arm;
  logic ring_s1_q, ring_s2_q, ring_prev_q, tick;
  logic [TW-1:0] tmr_q;
  logic [RW-1:0] ring_cnt_q;
  logic [RW-1:0] intv_target;
  logic wake_pend_q;
  logic flag_set;

  // ****************************************
  // synchronisers
  // ****************************************
  // two-flop comparator sync
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_s1_q <= '0;
      cmp_s2_q <= '0;
    end else if (ce_i) begin
      cmp_s1_q <= cmp_i;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // ring sampled; chain resets high so a ring already high gives no false tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_s1_q <= 1'b1;
      ring_s2_q <= 1'b1;
      ring_prev_q <= 1'b1;
    end else if (ce_i) begin
      ring_s1_q <= ring_clk_i;
      ring_s2_q <= ring_s1_q;
      ring_prev_q <= ring_s2_q;
    end
  end
  assign tick = ring_s2_q && !ring_prev_q;

  // ****************************************
  // dip filter
  // ****************************************
  // power-on comparator always armed, the others only while the monitor is powered
  assign arm = '{above_warning: monitor_pwr_o, above_reset: monitor_pwr_o, above_poweron: 1'b1};

  spfs_filter #(
    .CYC(`SPFS_DETECT_CYC)
  ) u_filter (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .raw_i(cmp_s2_q),
    .arm_i(arm),
    .good_o(cmp_good)
  );

  // ****************************************
  // configuration
  // ****************************************
  // disable reset asserted
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_monitor_disable_o <= `SPFS_DISABLE_RST;
    end else if (ce_i && disable_wr_i) begin
      stop_monitor_disable_o <= disable_val_i;
    end
  end

  // interval in ring ticks, zero for continuous
  assign intv_target = (interval_sel_i == 2'h0) ? RW'(0) : RW'(1) << (`SPFS_INTV_LOG2_BASE + interval_sel_i);

  // ****************************************
  // sequencer
  // ****************************************
  // warning flag set by a detected warning in stop or on the wake check
  assign flag_set = ((state_q == SPFS_STOP) && !stop_monitor_disable_o && cmp_good.above_reset
                     && !cmp_good.above_warning)
                 || ((state_q == SPFS_WAKE_CHECK) && (tmr_q == TW'(`SPFS_WAKE_CHK_CYC))
                     && cmp_s2_q.above_reset && !cmp_s2_q.above_warning);

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_warning_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (flag_set) begin
        supply_warning_flag_o <= 1'b1;
      end else if (flag_clear_i) begin
        supply_warning_flag_o <= 1'b0;
      end
    end
  end

  // main state machine with its timers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SPFS_POR_HOLD;
      tmr_q <= '0;
      ring_cnt_q <= '0;
      wake_pend_q <= 1'b0;
      stop_exit_o <= 1'b0;
      resume_o <= 1'b0;
      dispatch_o <= SPFS_DISP_NONE;
    end else if (ce_i) begin
      stop_exit_o <= 1'b0;
      resume_o <= 1'b0;
      if (!cmp_good.above_poweron) begin
        state_q <= SPFS_POR_HOLD;
        wake_pend_q <= 1'b0;
      end else begin
        case (state_q)
          SPFS_RUN: begin
            if (stop_req_i) begin
              state_q <= SPFS_STOP;
              wake_pend_q <= 1'b0;
            end
          end
          SPFS_STOP: begin
            tmr_q <= '0;
            if (!stop_monitor_disable_o && !cmp_good.above_reset) begin
              state_q <= SPFS_RST_WAIT;
              ring_cnt_q <= '0;
            end else if (!stop_monitor_disable_o && !cmp_good.above_warning) begin
              state_q <= SPFS_WARMUP;
              wake_pend_q <= wake_irq_i;
            end else if (wake_irq_i) begin
              wake_pend_q <= 1'b1;
              state_q <= stop_monitor_disable_o ? SPFS_WAKE_CHECK : SPFS_WARMUP;
            end
          end
          SPFS_WAKE_CHECK: begin
            tmr_q <= tmr_q + TW'(1);
            if (tmr_q == TW'(`SPFS_WAKE_CHK_CYC)) begin
              tmr_q <= '0;
              if (!cmp_s2_q.above_reset) begin
                state_q <= SPFS_RST_WAIT;
                ring_cnt_q <= '0;
              end else begin
                state_q <= SPFS_WARMUP;
              end
            end
          end
          SPFS_WARMUP: begin
            tmr_q <= tmr_q + TW'(1);
            if (tmr_q == TW'(XTAL_CYC - 1)) begin
              tmr_q <= '0;
              state_q <= SPFS_RUN;
              stop_exit_o <= 1'b1;
              dispatch_o <= !supply_warning_flag_o ? (wake_pend_q ? SPFS_DISP_WAKE : SPFS_DISP_NONE)
                          : (wake_pend_q && !pfail_prio_high_i) ? SPFS_DISP_WAKE : SPFS_DISP_PFAIL;
            end
          end
          SPFS_POR_HOLD: begin
            state_q <= SPFS_RST_SAMPLE;
            ring_cnt_q <= '0;
            tmr_q <= '0;
          end
          SPFS_RST_WAIT: begin
            ring_cnt_q <= ring_cnt_q + RW'(tick);
            if (ring_cnt_q >= intv_target) begin
              state_q <= SPFS_RST_SAMPLE;
              ring_cnt_q <= '0;
            end
          end
          SPFS_RST_SAMPLE: begin
            ring_cnt_q <= ring_cnt_q + RW'(tick);
            if (tick && (ring_cnt_q == RW'(`SPFS_SAMPLE_TICKS - 1))) begin
              ring_cnt_q <= '0;
              state_q <= cmp_s2_q.above_reset ? SPFS_RST_CONFIRM : SPFS_RST_WAIT;
            end
          end
          SPFS_RST_CONFIRM: begin
            if (!cmp_s2_q.above_reset) begin
              state_q <= SPFS_RST_WAIT;
              ring_cnt_q <= '0;
            end else if (tick) begin
              ring_cnt_q <= ring_cnt_q + RW'(1);
              if (ring_cnt_q == RW'(`SPFS_CONFIRM_TICKS - 1)) begin
                ring_cnt_q <= '0;
                tmr_q <= '0;
                state_q <= SPFS_RST_WARMUP;
              end
            end
          end
          SPFS_RST_WARMUP: begin
            tmr_q <= tmr_q + TW'(1);
            if (tmr_q == TW'(XTAL_CYC - 1)) begin
              tmr_q <= '0;
              state_q <= SPFS_RUN;
              resume_o <= 1'b1;
              dispatch_o <= SPFS_DISP_NONE;
            end
          end
          default: begin
            state_q <= SPFS_POR_HOLD;
          end
        endcase
      end
    end
  end

  // ****************************************
  // power outputs, registered from the state
  // ****************************************
  // packed order: regulator, crystal, monitor, cpu reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'h1;
      resume_addr_o <= `SPFS_UTIL_ENTRY;
    end else if (ce_i) begin
      resume_addr_o <= `SPFS_UTIL_ENTRY;
      case (state_q)
        SPFS_RUN, SPFS_WARMUP: {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'he;
        SPFS_STOP: begin
          {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= {2'h0, !stop_monitor_disable_o, 1'h0};
        end
        SPFS_WAKE_CHECK: {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'h2;
        SPFS_RST_WAIT: begin
          {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= {2'h0, interval_sel_i == 2'h0, 1'h1};
        end
        SPFS_RST_SAMPLE, SPFS_RST_CONFIRM: {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'h3;
        SPFS_RST_WARMUP: {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'hf;
        default: {regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o} <= 4'h1;
      endcase
    end
  end

endmodule

//--- verif/spfs_seq_monitor.sv
// Purpose: port checker for the stop-mode supply-fault sequencer
// Assumes: one clock domain, reset active high
// Notes: bound onto spfs_seq, sees its ports only
`timescale 1ns/10ps
`include "spfs_params.svh"
module spfs_seq_monitor
  import spfs_pkg::*;
#(
  parameter int unsigned XTAL_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire spfs_cmp_type cmp_i,
  input wire logic regulator_en_o,
  input wire logic crystal_en_o,
  input wire logic monitor_pwr_o,
  input wire logic cpu_reset_o,
  input wire logic supply_warning_flag_o,
  input wire logic stop_exit_o,
  input wire spfs_disp_type dispatch_o,
  input wire logic resume_o,
  input wire logic [`SPFS_ADDR_W-1:0] resume_addr_o
);
  // ****************************************
  // helper counts
  // ****************************************
  int unsigned xtal_q;
  int unsigned por_q;
  // crystal run length, saturating so it never wraps
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_q <= 0;
    end else if (!crystal_en_o) begin
      xtal_q <= 0;
    end else if (xtal_q < XTAL_CYC) begin
      xtal_q <= xtal_q + 1;
    end
  end
  // length of a power-on loss at the pin
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      por_q <= 0;
    end else if (cmp_i.above_poweron) begin
      por_q <= 0;
    end else if (por_q < 255) begin
      por_q <= por_q + 1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_exit_warm;
    stop_exit_o |-> xtal_q + 2 >= XTAL_CYC;
  endproperty
  a_exit_warm: assert property (p_exit_warm) else $error("stop exit before crystal warm-up");
  property p_resume;
    resume_o |-> (xtal_q + 2 >= XTAL_CYC && resume_addr_o == `SPFS_UTIL_ENTRY) ##1 !cpu_reset_o;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  property p_rst_off;
    $rose(cpu_reset_o) |-> !regulator_en_o && !crystal_en_o;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("regulator on at fault reset");
  property p_exit_disp;
    stop_exit_o |=> dispatch_o != SPFS_DISP_NONE && !stop_exit_o;
  endproperty
  a_exit_disp: assert property (p_exit_disp) else $error("exit without dispatch");
  property p_flag_mon;
    $rose(supply_warning_flag_o) |-> $past(monitor_pwr_o);
  endproperty
  a_flag_mon: assert property (p_flag_mon) else $error("flag set with monitor off");
  property p_warn_power;
    $rose(supply_warning_flag_o) |-> ##[0:2] regulator_en_o && crystal_en_o;
  endproperty
  a_warn_power: assert property (p_warn_power) else $error("warning without restart");
  property p_por;
    por_q >= 220 |-> cpu_reset_o && !regulator_en_o && !crystal_en_o && !monitor_pwr_o;
  endproperty
  a_por: assert property (p_por) else $error("not held below power-on");
  property p_resume_once;
    resume_o |=> !resume_o ##1 !resume_o;
  endproperty
  a_resume_once: assert property (p_resume_once) else $error("resume pulse too long");
endmodule

bind spfs_seq spfs_seq_monitor #(.XTAL_CYC(XTAL_CYC)) u_mon (.mclk_i, .rst_i, .cmp_i, .regulator_en_o,
  .crystal_en_o, .monitor_pwr_o, .cpu_reset_o, .supply_warning_flag_o, .stop_exit_o, .dispatch_o, .resume_o,
  .resume_addr_o);

//--- verif/spfs_supply_model.sv
// Purpose: supply comparators and ring oscillator facing the sequencer
// Assumes: level 0 below power-on, 1 below reset, 2 below warning, 3 good
// Notes: ring oscillator runs free, unrelated in phase to mclk
`timescale 1ns/10ps
module spfs_supply_model
  import spfs_pkg::*;
#(
  parameter int unsigned RING_HALF = 50
) (
  input wire logic [1:0] level_i,
  output spfs_cmp_type cmp_o,
  output logic ring_clk_o
);
  // ****************************************
  // comparators, high while above
  // ****************************************
  assign cmp_o = '{above_warning: level_i == 2'h3, above_reset: level_i >= 2'h2, above_poweron: level_i != 2'h0};
  // slow oscillator, odd offset keeps it off the mclk edges
  initial begin
    ring_clk_o = 1'b0;
    #3;
    forever #(RING_HALF) ring_clk_o = ~ring_clk_o;
  end
endmodule

//--- verif/spfs_seq_tb_top.sv
// Purpose: self-checking bench of the supply-fault sequencer
// Assumes: short crystal warm-up, ring tick every 10 mclk cycles
// Notes: inputs change at rising edges, outputs read at falling edges
`timescale 1ns/10ps
`include "spfs_params.svh"
module spfs_seq_tb_top;
  import spfs_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, stop_req_i = 1'b0, wake_irq_i = 1'b0;
  logic pfail_prio_high_i = 1'b0, disable_wr_i = 1'b0, disable_val_i = 1'b0, flag_clear_i = 1'b0;
  logic [1:0] interval_sel_i = 2'h0, level = 2'h3;
  logic ring_clk, regulator_en_o, crystal_en_o, monitor_pwr_o, cpu_reset_o, supply_warning_flag_o;
  logic stop_exit_o, resume_o, stop_monitor_disable_o;
  logic [`SPFS_ADDR_W-1:0] resume_addr_o;
  spfs_cmp_type cmp;
  spfs_disp_type dispatch_o;
  int fail_count = 0, comparisons = 0;
  int ev, mon;

  spfs_supply_model u_sup (.level_i(level), .cmp_o(cmp), .ring_clk_o(ring_clk));
  spfs_seq #(.XTAL_CYC(20)) DUT (.mclk_i, .rst_i, .ce_i, .ring_clk_i(ring_clk), .cmp_i(cmp), .stop_req_i,
    .wake_irq_i, .pfail_prio_high_i, .disable_wr_i, .disable_val_i, .interval_sel_i, .flag_clear_i,
    .regulator_en_o, .crystal_en_o, .monitor_pwr_o, .cpu_reset_o, .supply_warning_flag_o, .stop_exit_o,
    .dispatch_o, .resume_o, .resume_addr_o, .stop_monitor_disable_o);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one-cycle strobe: 0 stop, 1 wake, 2 flag clear, 3 disable write
  task automatic pulse(input int k);
    @(posedge mclk_i);
    case (k)
      0: stop_req_i <= 1'b1;
      1: wake_irq_i <= 1'b1;
      2: flag_clear_i <= 1'b1;
      default: disable_wr_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    {stop_req_i, wake_irq_i, flag_clear_i, disable_wr_i} <= 4'h0;
  endtask
  // bounded wait for resume (1) or stop exit (0)
  task automatic wait_for(input bit res);
    for (int n = 0; n < 40000; n++) begin
      @(negedge mclk_i);
      if ((res ? resume_o : stop_exit_o) === 1'b1) begin
        return;
      end
    end
    fail_count++;
    $display("MISMATCH pulse expected 1 seen 0");
    close_out();
  endtask
  // counts cycles with exit, reset or flag up, and with monitor on
  task automatic watch(input int n);
    ev = 0;
    mon = 0;
    repeat (n) begin
      @(negedge mclk_i);
      ev += ((stop_exit_o | cpu_reset_o | supply_warning_flag_o) === 1'b1);
      mon += (monitor_pwr_o === 1'b1);
    end
  endtask
  task automatic go_stop(input logic [1:0] lvl);
    pulse(0);
    repeat (5) @(posedge mclk_i);
    level <= lvl;
  endtask
  task automatic recover(input bit res);
    @(posedge mclk_i);
    level <= 2'h3;
    if (res) begin
      wait_for(1'b1);
    end
    pulse(2);
  endtask
  task automatic set_disable(input logic v);
    @(posedge mclk_i);
    disable_val_i <= v;
    pulse(3);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_boot;
    check("disable", stop_monitor_disable_o, 1'b1);
    check("held", cpu_reset_o, 1'b1);
    wait_for(1'b1);
    check("addr", resume_addr_o, `SPFS_UTIL_ENTRY);
    @(negedge mclk_i);
    check("released", cpu_reset_o, 1'b0);
    $display("test boot done");
  endtask
  // dip ignored while disabled, then wake finds it; both priorities
  task automatic t_disabled(input logic prio);
    go_stop(2'h2);
    watch(400);
    check("ignored", ev, 0);
    check("unpowered", mon, 0);
    @(posedge mclk_i);
    pfail_prio_high_i <= prio;
    pulse(1);
    wait_for(1'b0);
    @(negedge mclk_i);
    check("flag", supply_warning_flag_o, 1'b1);
    check("regulator", regulator_en_o, 1'b1);
    check("dispatch", dispatch_o, prio ? SPFS_DISP_PFAIL : SPFS_DISP_WAKE);
    recover(1'b0);
    $display("test disabled wake done");
  endtask
  task automatic t_enabled_warn;
    set_disable(1'b0);
    go_stop(2'h2);
    repeat (100) @(posedge mclk_i);
    level <= 2'h3;
    watch(400);
    check("short dip", ev, 0);
    check("powered", mon, 400);
    @(posedge mclk_i);
    level <= 2'h2;
    wait_for(1'b0);
    @(negedge mclk_i);
    check("flag", supply_warning_flag_o, 1'b1);
    check("dispatch", dispatch_o, SPFS_DISP_PFAIL);
    recover(1'b0);
    $display("test enabled warning done");
  endtask
  task automatic t_enabled_reset;
    @(posedge mclk_i);
    interval_sel_i <= 2'h1;
    go_stop(2'h1);
    watch(300);
    check("reset", cpu_reset_o, 1'b1);
    check("crystal", crystal_en_o, 1'b0);
    watch(2000);
    check("periodic", mon, 0);
    @(posedge mclk_i);
    level <= 2'h3;
    watch(15000);
    check("interval", ev, 15000);
    check("interval off", mon, 0);
    recover(1'b1);
    check("dispatch", dispatch_o, SPFS_DISP_NONE);
    interval_sel_i <= 2'h0;
    $display("test enabled reset done");
  endtask
  task automatic t_wake_reset;
    set_disable(1'b1);
    go_stop(2'h1);
    pulse(1);
    watch(300);
    check("reset", cpu_reset_o, 1'b1);
    check("regulator", regulator_en_o, 1'b0);
    recover(1'b1);
    $display("test wake reset done");
  endtask
  task automatic t_por;
    @(posedge mclk_i);
    level <= 2'h0;
    watch(300);
    check("held", cpu_reset_o, 1'b1);
    check("monitor", monitor_pwr_o, 1'b0);
    recover(1'b1);
    $display("test power-on loss done");
  endtask
  // longer intervals keep the monitor off past 2^11 ticks; a mid-run reset ends the wait
  task automatic t_long(input logic [1:0] sel);
    set_disable(1'b0);
    @(posedge mclk_i);
    interval_sel_i <= sel;
    go_stop(2'h1);
    watch(300);
    check("long reset", cpu_reset_o, 1'b1);
    watch(22000);
    check("long interval", mon, 0);
    @(posedge mclk_i);
    level <= 2'h3;
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    check("disable after reset", stop_monitor_disable_o, 1'b1);
    check("held after reset", cpu_reset_o, 1'b1);
    wait_for(1'b1);
    @(posedge mclk_i);
    interval_sel_i <= 2'h0;
    $display("test long interval done");
  endtask

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_boot();
    t_disabled(1'b1);
    t_disabled(1'b0);
    t_enabled_warn();
    t_enabled_reset();
    t_wake_reset();
    t_por();
    t_long(2'h2);
    t_long(2'h3);
    close_out();
  end
endmodule
